// File: src/lba_pkg.sv
/*
  Shared constants for the level-two memory bandwidth arbiter:
  register offsets, field positions, reset values and widths.
  Assumes a 32-bit AXI4-Lite register bus and one 50 MHz clock.
*/
`default_nettype none

package lba_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int PRIO_W   = 3;
  localparam int WAIT_W   = 8;
  localparam int ADDR_W   = 5;
  localparam int NUM_REQ  = 4;

  // Requestor index inside the grant vector
  localparam int REQ_GCOH = 0;
  localparam int REQ_CPU  = 1;
  localparam int REQ_DMA  = 2;
  localparam int REQ_UCOH = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CPU_PRIO  = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_INTERNAL_DMA_ENGINE_PRIO = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_THRESH    = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 5'h0C;

  // Register select codes from the address decode
  localparam logic [1:0] SEL_CPU_PRIO  = 2'h0;
  localparam logic [1:0] SEL_INTERNAL_DMA_ENGINE_PRIO = 2'h1;
  localparam logic [1:0] SEL_THRESH    = 2'h2;
  localparam logic [1:0] SEL_STATUS    = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values; a zero threshold field selects the default
  localparam logic [PRIO_W-1:0] RST_CPU_PRIO   = 3'h1;
  localparam logic [PRIO_W-1:0] RST_INTERNAL_DMA_ENGINE_PRIO  = 3'h4;
  localparam logic [WAIT_W-1:0] RST_THRESH     = 8'h00;
  localparam logic [WAIT_W-1:0] THRESH_DEFAULT = 8'h10;

  // Field positions
  localparam int THR_EFF_LSB    = 8;
  localparam int STAT_DMA_LSB   = 0;
  localparam int STAT_CPU_LSB   = 8;
  localparam int STAT_UCOH_LSB  = 16;
  localparam int STAT_GNT_LSB   = 24;
  localparam int STAT_ALT_BIT   = 28;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : lba_pkg

`default_nettype wire

// File: src/lba_starve_cnt.sv
/*
  Saturating lost-arbitration counter for one requestor.
  Assumes inc and clr come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module lba_starve_cnt
  import lba_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Control
  input  wire logic              inc,
  input  wire logic              clr,
  input  wire logic [WAIT_W-1:0] thresh,
  // State
  output logic      [WAIT_W-1:0] count,
  output logic                   starved
);

  logic [WAIT_W-1:0] count_r;
  logic [WAIT_W-1:0] count_nxt;

  // Holds at the threshold; a lowered threshold still counts as reached
  assign starved = (count_r >= thresh);
  assign count   = count_r;

  // Grant clears first, so tracking restarts after every win
  assign count_nxt = clr ? '0 :
                     (inc && !starved) ? WAIT_W'(count_r + 1'b1) : count_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the counter, one set per requestor
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // A lost cycle below the threshold adds exactly one
  property p_cnt_inc;
    (inc && !clr && !starved) |=> count_r == WAIT_W'($past(count_r) + 1'b1);
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) // R08
    else $error("lost-cycle counter did not advance");

  // Saturated counter holds rather than wrapping
  property p_cnt_sat;
    (starved && !clr) |=> count_r == $past(count_r);
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) // R09
    else $error("saturated counter moved");

  // A grant restarts starvation tracking
  property p_cnt_clr;
    clr |=> count_r == '0;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) // R12
    else $error("counter not cleared after grant");

endmodule : lba_starve_cnt

`default_nettype wire

// File: src/lba_arbiter.sv
/*
  Level-two memory bandwidth arbiter with its AXI4-Lite register slave.
  Grants one of global coherence, processor, DMA and user coherence
  each cycle. Requests come from logic on REF_CLK and need no sync.
*/
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// (R01) Four requestors: processor, DMA (slave and internal), user and global coherence.
// (R02) Global coherence always wins; user coherence ranks last unless its counter has reached the threshold.
// (R03) Processor versus DMA: numerically higher command priority wins the cycle.
// (R04) Each requestor counts lost cycles; reaching the threshold forces its win. Here DMA counts only cycles lost to the processor.
// (R05) Threshold comes from software setting, or the default when left zero.
// (R06) Slave DMA priority arrives with the command; internal DMA uses a register.
// (R07) Processor priority is held in a software-written register.
// (R08) DMA counter advances each cycle a processor access blocks DMA.
// (R09) DMA counter saturates at threshold and DMA then beats the processor.
// (R10) Equal priorities alternate grants between processor and DMA.
// (R11) Software should set processor priority below DMA priority.
// (R12) DMA counter clears to zero whenever DMA is granted.
module lba_arbiter
  import lba_pkg::*;
(
  // Clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              ARST_N,
  // Requestors
  input  wire logic              GCOH_REQ,
  input  wire logic              CPU_REQ,
  input  wire logic              SLAVE_DMA_PORT_REQ,
  input  wire logic [PRIO_W-1:0] SLAVE_DMA_PORT_PRIO,
  input  wire logic              INTERNAL_DMA_ENGINE_REQ,
  input  wire logic              UCOH_REQ,
  // Grants
  output logic                   GCOH_GNT,
  output logic                   CPU_GNT,
  output logic                   SLAVE_DMA_PORT_GNT,
  output logic                   INTERNAL_DMA_ENGINE_GNT,
  output logic                   UCOH_GNT,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by read and write: {hit, select}
  function automatic logic [2:0] lba_decode(input logic [ADDR_W-1:0] addr);
    logic [2:0] res;
    unique case (addr)
      OFS_CPU_PRIO:  res = {1'b1, SEL_CPU_PRIO};
      OFS_INTERNAL_DMA_ENGINE_PRIO: res = {1'b1, SEL_INTERNAL_DMA_ENGINE_PRIO};
      OFS_THRESH:    res = {1'b1, SEL_THRESH};
      OFS_STATUS:    res = {1'b1, SEL_STATUS};
      default:       res = 3'h0;
    endcase
    return res;
  endfunction : lba_decode

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [PRIO_W-1:0]  cpu_prio_r;
  logic [PRIO_W-1:0]  internal_dma_engine_prio_r;
  logic [WAIT_W-1:0]  thr_r;
  logic [NUM_REQ-1:0] gnt_r;
  logic               alt_r;
  logic               alt_nxt;
  logic               aw_held_r;
  logic [ADDR_W-1:0]  awaddr_r;
  logic               w_held_r;
  logic [31:0]        wdata_r;
  logic               wstrb0_r;
  logic               bvalid_r;
  logic [1:0]         bresp_r;
  logic               rvalid_r;
  logic [31:0]        rdata_r;
  logic [1:0]         rresp_r;
  logic [2:0]         wr_dec;
  logic [2:0]         rd_dec;
  logic               do_write;
  logic               wr_lane0;
  logic               rd_take;
  logic [31:0]        rd_mux;
  logic [WAIT_W-1:0]  thresh_eff;
  logic               dma_req;
  logic [PRIO_W-1:0]  dma_prio;
  logic               contest;
  logic               prio_eq;
  logic               ucoh_force;
  logic               tie_win;
  logic [NUM_REQ-1:0] gnt;
  logic [NUM_REQ-1:0] cnt_inc;
  logic [NUM_REQ-1:0] cnt_clr;
  logic [NUM_REQ-1:0] starved;
  logic [WAIT_W-1:0]  cnt [NUM_REQ];
  ////////////////////////////////////////////////////////////////////////////
  // Threshold and DMA priority source
  assign thresh_eff = (thr_r == '0) ? THRESH_DEFAULT : thr_r;        // R05
  assign dma_req    = SLAVE_DMA_PORT_REQ | INTERNAL_DMA_ENGINE_REQ;                            // R01
  // Slave DMA takes the DMA slot first; internal DMA fills idle slots
  assign dma_prio   = SLAVE_DMA_PORT_REQ ? SLAVE_DMA_PORT_PRIO : internal_dma_engine_prio_r;             // R06
  // Contest terms between processor and DMA
  assign contest    = CPU_REQ && dma_req;
  assign prio_eq    = (dma_prio == cpu_prio_r);
  assign ucoh_force = UCOH_REQ && starved[REQ_UCOH];
  assign tie_win    = contest && prio_eq && !GCOH_REQ && !ucoh_force
                      && !starved[REQ_DMA] && !starved[REQ_CPU];

  ////////////////////////////////////////////////////////////////////////////
  // Grant selection, global first, starved next, then priority
  always_comb begin
    gnt = '0;
    if (GCOH_REQ) begin
      gnt[REQ_GCOH] = 1'b1;                                           // R02
    end else if (ucoh_force) begin
      gnt[REQ_UCOH] = 1'b1;                                           // R04
    end else if (contest) begin
      if (starved[REQ_DMA]) begin
        gnt[REQ_DMA] = 1'b1;                                          // R09
      end else if (starved[REQ_CPU]) begin
        gnt[REQ_CPU] = 1'b1;                                          // R04
      end else if (dma_prio > cpu_prio_r) begin
        gnt[REQ_DMA] = 1'b1;                                          // R03
      end else if (dma_prio < cpu_prio_r) begin
        gnt[REQ_CPU] = 1'b1;                                          // R03
      end else if (alt_r) begin
        gnt[REQ_DMA] = 1'b1;                                          // R10
      end else begin
        gnt[REQ_CPU] = 1'b1;                                          // R10
      end
    end else if (CPU_REQ) begin
      gnt[REQ_CPU] = 1'b1;
    end else if (dma_req) begin
      gnt[REQ_DMA] = 1'b1;
    end else if (UCOH_REQ) begin
      gnt[REQ_UCOH] = 1'b1;                                           // R02
    end
  end

  // Grant fan-out to the ports
  assign GCOH_GNT = gnt[REQ_GCOH];
  assign CPU_GNT  = gnt[REQ_CPU];
  assign SLAVE_DMA_PORT_GNT = gnt[REQ_DMA] && SLAVE_DMA_PORT_REQ;
  assign INTERNAL_DMA_ENGINE_GNT = gnt[REQ_DMA] && !SLAVE_DMA_PORT_REQ;
  assign UCOH_GNT = gnt[REQ_UCOH];
  // Alternation flips only when the tie itself decided the slot
  assign alt_nxt = tie_win ? !alt_r : alt_r;                          // R10
  ////////////////////////////////////////////////////////////////////////////
  // Lost-cycle counters; DMA counts only cycles lost to the processor
  assign cnt_inc[REQ_GCOH] = 1'b0;
  assign cnt_inc[REQ_CPU]  = CPU_REQ && !gnt[REQ_CPU];                // R04
  assign cnt_inc[REQ_DMA]  = dma_req && gnt[REQ_CPU];                 // R08
  assign cnt_inc[REQ_UCOH] = UCOH_REQ && !gnt[REQ_UCOH];              // R04
  assign cnt_clr           = gnt;                                     // R12

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REQ; gi++) begin : g_cnt
      lba_starve_cnt u_cnt (
        .clk     (REF_CLK),
        .arst_n  (ARST_N),
        .inc     (cnt_inc[gi]),
        .clr     (cnt_clr[gi]),
        .thresh  (thresh_eff),
        .count   (cnt[gi]),
        .starved (starved[gi])
      );
    end
  endgenerate

  // Arbiter history for status
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      alt_r <= 1'b0;
      gnt_r <= '0;
    end else begin
      alt_r <= alt_nxt;
      gnt_r <= gnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI write: address and data latched separately, either order
  assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
  assign S_AXI_WREADY  = !w_held_r && !bvalid_r;
  assign do_write      = aw_held_r && w_held_r && !bvalid_r;
  assign wr_dec        = lba_decode(awaddr_r);
  // Registers sit in byte lane 0; other lanes carry nothing
  assign wr_lane0      = do_write && wr_dec[2] && wstrb0_r;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      w_held_r <= 1'b0;
      wdata_r  <= '0;
      wstrb0_r <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held_r <= 1'b1;
      wdata_r  <= S_AXI_WDATA;
      wstrb0_r <= S_AXI_WSTRB[0];
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_dec[2] ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP  = bresp_r;
  // Software-owned settings; status writes are dropped
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cpu_prio_r  <= RST_CPU_PRIO;
      internal_dma_engine_prio_r <= RST_INTERNAL_DMA_ENGINE_PRIO;
      thr_r       <= RST_THRESH;
    end else if (wr_lane0) begin
      if (wr_dec[1:0] == SEL_CPU_PRIO) begin
        cpu_prio_r <= wdata_r[PRIO_W-1:0];                            // R07
      end
      if (wr_dec[1:0] == SEL_INTERNAL_DMA_ENGINE_PRIO) begin
        internal_dma_engine_prio_r <= wdata_r[PRIO_W-1:0];                           // R06
      end
      if (wr_dec[1:0] == SEL_THRESH) begin
        thr_r <= wdata_r[WAIT_W-1:0];                                 // R05
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read: one outstanding read, data one cycle after the address
  assign S_AXI_ARREADY = !rvalid_r;
  assign rd_take       = S_AXI_ARVALID && !rvalid_r;
  assign rd_dec        = lba_decode(S_AXI_ARADDR);
  // Read mux; status shows live counters and the last grant
  always_comb begin
    rd_mux = '0;
    unique case (rd_dec[1:0])
      SEL_CPU_PRIO:  rd_mux[PRIO_W-1:0] = cpu_prio_r;
      SEL_INTERNAL_DMA_ENGINE_PRIO: rd_mux[PRIO_W-1:0] = internal_dma_engine_prio_r;
      SEL_THRESH: begin
        rd_mux[WAIT_W-1:0]                      = thr_r;
        rd_mux[THR_EFF_LSB +: WAIT_W]           = thresh_eff;
      end
      SEL_STATUS: begin
        rd_mux[STAT_DMA_LSB +: WAIT_W]          = cnt[REQ_DMA];
        rd_mux[STAT_CPU_LSB +: WAIT_W]          = cnt[REQ_CPU];
        rd_mux[STAT_UCOH_LSB +: WAIT_W]         = cnt[REQ_UCOH];
        rd_mux[STAT_GNT_LSB +: NUM_REQ]         = gnt_r;
        rd_mux[STAT_ALT_BIT]                    = alt_r;
      end
    endcase
    if (!rd_dec[2]) begin
      rd_mux = '0;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_dec[2] ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA  = rdata_r;
  assign S_AXI_RRESP  = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the arbitration
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!ARST_N);
  // Exactly one grant whenever anyone asks
  property p_one_grant;
    (GCOH_REQ || CPU_REQ || dma_req || UCOH_REQ) |->
      $onehot({GCOH_GNT, CPU_GNT, SLAVE_DMA_PORT_GNT, INTERNAL_DMA_ENGINE_GNT, UCOH_GNT});
  endproperty
  a_one_grant: assert property (p_one_grant) // R01
    else $error("request without exactly one grant");
  // Global coherence beats everything
  property p_gcoh_first;
    GCOH_REQ |-> GCOH_GNT && !CPU_GNT && !SLAVE_DMA_PORT_GNT && !INTERNAL_DMA_ENGINE_GNT && !UCOH_GNT;
  endproperty
  a_gcoh_first: assert property (p_gcoh_first) // R02
    else $error("global coherence request not granted");
  // User coherence wins only when alone or starved
  property p_ucoh_last;
    (UCOH_GNT && !starved[REQ_UCOH]) |-> !(GCOH_REQ || CPU_REQ || dma_req);
  endproperty
  a_ucoh_last: assert property (p_ucoh_last) // R02
    else $error("user coherence granted over another requestor");
  // Higher DMA priority wins an unforced contest
  property p_prio;
    (contest && !GCOH_REQ && !ucoh_force && !starved[REQ_CPU]
     && dma_prio > cpu_prio_r) |-> (SLAVE_DMA_PORT_GNT || INTERNAL_DMA_ENGINE_GNT);
  endproperty
  a_prio: assert property (p_prio) // R03
    else $error("higher priority DMA lost to processor");
  // Saturated DMA counter forces DMA over processor
  property p_dma_forced;
    (contest && starved[REQ_DMA] && !GCOH_REQ && !ucoh_force) |-> !CPU_GNT;
  endproperty
  a_dma_forced: assert property (p_dma_forced) // R09
    else $error("starved DMA did not win");
  // Back-to-back ties alternate processor then DMA
  property p_alt;
    (tie_win && CPU_GNT) ##1 tie_win |-> (SLAVE_DMA_PORT_GNT || INTERNAL_DMA_ENGINE_GNT);
  endproperty
  a_alt: assert property (p_alt) // R10
    else $error("equal priority tie did not alternate");
  // Processor priority write lands on the next edge
  property p_cpu_prio_wr;
    (wr_lane0 && wr_dec[1:0] == SEL_CPU_PRIO) |=>
      cpu_prio_r == $past(wdata_r[PRIO_W-1:0]) && S_AXI_BVALID;
  endproperty
  a_cpu_prio_wr: assert property (p_cpu_prio_wr) // R07
    else $error("processor priority write lost");

endmodule : lba_arbiter

`default_nettype wire

// File: bench/lba_req_model.sv
/*
  Requestor-side model: global coherence, processor, slave DMA,
  internal DMA and user coherence. Assumes grants are combinational on clk.
*/
`timescale 1ns/10ps
`default_nettype none

module lba_req_model (
  // Clock, reset, traffic level: 0 none, 1 sparse, 2 heavy
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [1:0] mode,
  // Grants {gcoh, cpu, slave_dma_port, internal_dma_engine, ucoh}
  input  wire logic [4:0] gnt,
  // Requests in the same order, slave DMA priority
  output logic      [4:0] req,
  output logic      [2:0] slave_dma_port_prio
);
  integer seed = 32'h8126_592b;
  logic   nxt;

  ////////////////////////////////////////
  // Losers hold; heavy mode keeps the controller busy every cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req       <= 5'h00;
      slave_dma_port_prio <= 3'h0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        nxt = (mode == 2'h2) ? ((i != 4) || (($random(seed) & 15) == 0)) :
              (mode == 2'h1) ? $random(seed) & 1 : 1'b0;
        if (!req[i] || gnt[i]) req[i] <= nxt;
      end
      // Priority travels with each new slave DMA command
      if (!req[2] || gnt[2]) slave_dma_port_prio <= 3'($random(seed));
    end
  end
endmodule : lba_req_model

`default_nettype wire

// File: bench/lba_arbiter_test.sv
/*
  Self-checking bench for the bandwidth arbiter: grant model every cycle,
  register access over AXI4-Lite. Assumes lba_pkg and a 50 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none

module lba_arbiter_test;
  import lba_pkg::*;

  logic              ref_clk = 1'b0;
  logic              arst_n;
  logic [1:0]        mode = 2'h0;
  logic [4:0]        req, gnt, eg;
  logic [2:0]        sprio;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, rdata;
  logic [3:0]        wstrb = '0;
  logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic              awready, wready, bvalid, arready, rvalid, alt, tie, dr;
  logic [1:0]        bresp, rresp;
  int                n_mismatch = 0, check_count = 0;
  int                dc, cc, uc, w, dp, n;
  int                thr = int'(THRESH_DEFAULT), cp = int'(RST_CPU_PRIO), ip = int'(RST_INTERNAL_DMA_ENGINE_PRIO), fld;
  int                cpv[4] = '{1, 4, 3, 2};
  int                ipv[4] = '{4, 1, 3, 2};
  int                thv[4] = '{2, 5, 8, 0};

  initial arst_n = 1'b0;
  // Free-running clock
  initial forever #10 ref_clk = ~ref_clk;

  lba_arbiter dut (
    .REF_CLK(ref_clk), .ARST_N(arst_n),
    .GCOH_REQ(req[4]), .CPU_REQ(req[3]), .SLAVE_DMA_PORT_REQ(req[2]), .SLAVE_DMA_PORT_PRIO(sprio),
    .INTERNAL_DMA_ENGINE_REQ(req[1]), .UCOH_REQ(req[0]),
    .GCOH_GNT(gnt[4]), .CPU_GNT(gnt[3]), .SLAVE_DMA_PORT_GNT(gnt[2]), .INTERNAL_DMA_ENGINE_GNT(gnt[1]), .UCOH_GNT(gnt[0]),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );

  lba_req_model reqs (
    .clk(ref_clk), .arst_n(arst_n), .mode(mode), .gnt(gnt), .req(req), .slave_dma_port_prio(sprio)
  );

  ////////////////////////////////////////
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Address and data offered together, each released once taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int k;
    k = 0;
    @(posedge ref_clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && k < 100);
    bready <= 1'b0;
    chk({bvalid, bresp}, {1'b1, er});
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && k < 100);
    rready <= 1'b0;
    chk({rvalid, rresp, rdata}, {1'b1, er, ed});
  endtask : rd

  task stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  function automatic int sat(input int c, input int t);
    return (c + 1 > t) ? t : c + 1;
  endfunction : sat

  ////////////////////////////////////////
  // Reference arbiter, evaluated mid-cycle when requests are settled
  always @(negedge ref_clk) begin
    if (!arst_n) begin
      dc  = 0;
      cc  = 0;
      uc  = 0;
      alt = 1'b0;
    end else begin
      dr  = req[2] | req[1];
      dp  = req[2] ? int'(sprio) : ip;
      tie = 1'b0;
      if (req[4]) w = 4;
      else if (req[0] && uc >= thr) w = 0;
      else if (req[3] && dr) begin
        if (dc >= thr) w = 2;
        else if (cc >= thr) w = 3;
        else if (cp != dp) w = (cp > dp) ? 3 : 2;
        else begin
          tie = 1'b1;
          w   = alt ? 2 : 3;
        end
      end
      else if (req[3]) w = 3;
      else if (dr) w = 2;
      else if (req[0]) w = 0;
      else w = -1;
      eg = (w == 2) ? (req[2] ? 5'h04 : 5'h02) : (w >= 0) ? 5'(1 << w) : 5'h00;
      chk(40'(gnt), 40'(eg));
      dc = (w == 2) ? 0 : (w == 3 && dr) ? sat(dc, thr) : dc;
      cc = (w == 3) ? 0 : req[3] ? sat(cc, thr) : cc;
      uc = (w == 0) ? 0 : req[0] ? sat(uc, thr) : uc;
      if (tie) alt = ~alt;
    end
  end

  ////////////////////////////////////////
  // Main sequence: reset values, bus corners, then priority sweeps
  initial begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    rd(OFS_CPU_PRIO, 32'h0000_0001, RESP_OKAY);
    rd(OFS_INTERNAL_DMA_ENGINE_PRIO, 32'h0000_0004, RESP_OKAY);
    rd(OFS_THRESH, 32'h0000_1000, RESP_OKAY);
    wr(OFS_CPU_PRIO, 32'h0000_0006, 4'h0, RESP_OKAY);
    rd(OFS_CPU_PRIO, 32'h0000_0001, RESP_OKAY);
    wr(OFS_STATUS, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    rd(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
    wr(5'h10, 32'h0000_0001, 4'hF, RESP_SLVERR);
    rd(5'h10, 32'h0000_0000, RESP_SLVERR);
    // Thresholds rise so no count ever sits above a new threshold
    for (int k = 0; k < 4; k++) begin
      cp  = cpv[k];
      ip  = ipv[k];
      fld = thv[k];
      wr(OFS_CPU_PRIO, 32'(cp), 4'hF, RESP_OKAY);
      wr(OFS_INTERNAL_DMA_ENGINE_PRIO, 32'(ip), 4'hF, RESP_OKAY);
      wr(OFS_THRESH, 32'(fld), 4'hF, RESP_OKAY);
      thr = (fld == 0) ? int'(THRESH_DEFAULT) : fld;
      rd(OFS_THRESH, 32'(thr * 256 + fld), RESP_OKAY);
      mode <= (k == 1) ? 2'h1 : 2'h2;
      repeat (400) @(posedge ref_clk);
      mode <= 2'h0;
      for (n = 0; n < 200 && req !== 5'h00; n++) @(posedge ref_clk);
      // Every held request must drain once no new traffic arrives
      chk(40'(req), 40'h00_0000_0000);
      repeat (2) @(posedge ref_clk);
      rd(OFS_STATUS, {3'h0, alt, 4'h0, 8'(uc), 8'(cc), 8'(dc)}, RESP_OKAY);
    end
    stop_test;
  end

  // Watchdog well beyond the roughly 1750 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    stop_test;
  end
endmodule : lba_arbiter_test

`default_nettype wire
